//--- core/mpms_sequencer.sv
/*
 * Power-mode sequencer of a stacked battery-monitor device: wake-up by the
 * interface supply edge or a reset pulse, chain wake-up relay, partial and
 * full power-down, the power-down timer and diagnostic output gating.
 * Assumes all pins arrive asynchronously; register writes come as same-clock
 * strobes from the serial decoder. The analog core is modelled by levels.
 */
`timescale 1ns/1ns
module mpms_sequencer
    import mpms_pkg::*;
#(
    parameter longint unsigned TICK_CYCLES   = mpms_pkg::TICK_CYC,
    parameter int unsigned     SETTLE_CYCLES = mpms_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // pins
    input  wire logic                    is_master,
    input  wire logic                    interface_supply_sense,
    input  wire logic                    reset_pin,
    input  wire logic                    chain_wake_in,
    input  wire logic                    watchdog_timeout,
    // register strobes
    input  mpms_pkg::mpms_ctrl_t         ctrl,
    input  mpms_pkg::mpms_diag_t         diag,
    input  wire logic [4:0]              dev_addr_in,
    input  wire logic                    dev_addr_load,
    // status and outputs
    output mpms_pkg::mpms_state_t        state,
    output logic                         spi_ready,
    output logic                         conv_ready,
    output logic                         chain_wake_out,
    output logic                         core_regulator_output,
    output logic [mpms_pkg::PDT_W-1:0]   powerdown_time_setting,
    output logic [mpms_pkg::PDT_W-1:0]   pd_count,
    output logic                         pd_timer_running,
    output logic [4:0]                   dev_addr,
    output logic                         regs_default,
    output logic [mpms_pkg::CH_N-1:0]    balance_out,
    output logic [mpms_pkg::CH_N-1:0]    open_sense_out
);
    import mpms_pkg::*;

    logic supply_s, reset_s, chain_s, wdt_s, master_s;
    logic supply_prev_q, reset_prev_q;
    logic [7:0] rst_len_q;
    logic wake_ev, reset_pulse_ok, hardware_powerdown_select_sel, pdt_active, expiry, sw_rst;
    logic ready_done, settle_done, relay_done, wdt_latch_q;
    mpms_state_t state_q;
    logic [PRE_W-1:0] pre_q;

    mpms_sync u_sync_sup (.clk(clk), .rst(rst), .d(interface_supply_sense), .q(supply_s));
    mpms_sync u_sync_rst (.clk(clk), .rst(rst), .d(reset_pin),              .q(reset_s));
    mpms_sync u_sync_chn (.clk(clk), .rst(rst), .d(chain_wake_in),          .q(chain_s));
    mpms_sync u_sync_wdt (.clk(clk), .rst(rst), .d(watchdog_timeout),       .q(wdt_s));
    mpms_sync u_sync_mst (.clk(clk), .rst(rst), .d(is_master),              .q(master_s));

    assign sw_rst   = ctrl.soft_reset;
    assign hardware_powerdown_select_sel = ctrl.ctrl1[HARDWARE_POWERDOWN_SELECT_BIT];

    // edge history and reset pulse width
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_prev_q <= 1'b0;
            reset_prev_q  <= 1'b0;
            rst_len_q     <= '0;
        end else begin
            supply_prev_q <= supply_s;
            reset_prev_q  <= reset_s;
            if (reset_s && rst_len_q != 8'hff)
                rst_len_q <= rst_len_q + 8'h01;
            else if (!reset_s)
                rst_len_q <= '0;
        end
    end

    // short glitches on the reset pin must not wake the chain
    assign reset_pulse_ok = reset_prev_q && !reset_s && supply_s
                            && (rst_len_q >= 8'(RESET_PULSE_CYC));
    assign wake_ev = master_s ? ((supply_s && !supply_prev_q) || reset_pulse_ok)
                              : (chain_s || reset_pulse_ok);

    // power-down timer setting; pin reset acts like power-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerdown_time_setting <= PDT_RESET;
        end else if (reset_pulse_ok || sw_rst) begin
            powerdown_time_setting <= PDT_RESET;
        end else if (ctrl.pdt_write) begin
            powerdown_time_setting <= ctrl.pdt_data;
        end
    end

    // address survives a software reset, only rst or a pin reset clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_addr <= '0;
        end else if (reset_pulse_ok) begin
            dev_addr <= '0;
        end else if (dev_addr_load) begin
            dev_addr <= dev_addr_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            regs_default <= 1'b1;
        else
            regs_default <= reset_pulse_ok || sw_rst;
    end

    // counts in any powered state, waking included
    assign pdt_active = hardware_powerdown_select_sel && (powerdown_time_setting != PDT_OFF)
                        && (state_q != MPMS_OFF);

    // prescaler and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q            <= '0;
            pd_count         <= '0;
            pd_timer_running <= 1'b0;
        end else if (!pdt_active || ctrl.pdt_write || !pd_timer_running) begin
            pre_q            <= '0;
            pd_count         <= '0;
            pd_timer_running <= pdt_active && !ctrl.pdt_write;
        end else if (pd_count != powerdown_time_setting) begin
            if (pre_q == PRE_W'(TICK_CYCLES - 1)) begin
                pre_q    <= '0;
                pd_count <= pd_count + 8'h01;
            end else begin
                pre_q <= pre_q + PRE_W'(1);
            end
        end
    end

    assign expiry = pd_timer_running && (pd_count == powerdown_time_setting)
                    && (master_s ? !supply_s : hardware_powerdown_select_sel);

    // watchdog off-state latch; master needs a supply or reset toggle to leave
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wdt_latch_q <= 1'b0;
        else if (wdt_s)
            wdt_latch_q <= 1'b1;
        else if (wake_ev)
            wdt_latch_q <= 1'b0;
    end

    // power state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= MPMS_OFF;
        end else begin
            case (state_q)
                MPMS_OFF: begin
                    if (wake_ev)
                        state_q <= MPMS_WAKING;
                end
                MPMS_WAKING, MPMS_ACTIVE, MPMS_PARTIAL: begin
                    if (wdt_s)
                        state_q <= MPMS_OFF;
                    else if (master_s && !supply_s && powerdown_time_setting == PDT_OFF)
                        state_q <= MPMS_OFF;
                    else if (master_s && !supply_s && !hardware_powerdown_select_sel)
                        state_q <= MPMS_OFF;
                    else if (!master_s && hardware_powerdown_select_sel && powerdown_time_setting == PDT_OFF)
                        state_q <= MPMS_OFF;
                    else if (expiry)
                        state_q <= MPMS_OFF;
                    else if (state_q == MPMS_WAKING && ready_done)
                        state_q <= MPMS_ACTIVE;
                    else if (state_q != MPMS_WAKING)
                        state_q <= ctrl.partial_req ? MPMS_PARTIAL : MPMS_ACTIVE;
                end
                default: state_q <= MPMS_OFF;
            endcase
        end
    end

    logic wake_start, in_off;
    assign wake_start = (state_q == MPMS_OFF) && wake_ev && !(wdt_latch_q && wdt_s);
    assign in_off     = (state_q == MPMS_OFF);

    mpms_delay #(.COUNT(SPI_READY_CYC), .W(CNT_W)) u_ready (
        .clk(clk), .rst(rst), .start(wake_start), .clear(in_off && !wake_start), .done(ready_done));
    mpms_delay #(.COUNT(SETTLE_CYCLES), .W(CNT_W)) u_settle (
        .clk(clk), .rst(rst), .start(wake_start), .clear(in_off && !wake_start), .done(settle_done));
    mpms_delay #(.COUNT(RELAY_CYC), .W(CNT_W)) u_relay (
        .clk(clk), .rst(rst), .start(wake_start), .clear(in_off && !wake_start), .done(relay_done));

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state                 <= MPMS_OFF;
            spi_ready             <= 1'b0;
            conv_ready            <= 1'b0;
            chain_wake_out        <= 1'b0;
            core_regulator_output <= 1'b0;
        end else begin
            state                 <= state_q;
            spi_ready             <= ready_done && !in_off;
            conv_ready            <= settle_done && !in_off;
            chain_wake_out        <= relay_done && !in_off;
            core_regulator_output <= !in_off;
        end
    end

    // diagnostic gating; delay mode hands control to the converter sequence
    logic [CH_N-1:0] os_all;
    assign os_all = diag.open_sense_control_reg
                    | {{(CH_N-4){1'b0}}, diag.open_sense_aux_control_reg};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            balance_out    <= '0;
            open_sense_out <= '0;
        end else if (in_off) begin
            balance_out    <= '0;
            open_sense_out <= '0;
        end else if (!diag.conversion_delay_select) begin
            balance_out    <= (ctrl.balance_driver_power && diag.output_gate_enable[0])
                              ? diag.balance_bits : '0;
            open_sense_out <= diag.output_gate_enable[1] ? os_all : '0;
        end else begin
            balance_out    <= ctrl.balance_driver_power ? diag.balance_bits : '0;
            open_sense_out <= os_all;
        end
    end
endmodule : mpms_sequencer

//--- core/mpms_pkg.sv
/*
 * Package for the power-mode sequencer: timing constants, the power-state
 * encoding, and the packed structs that carry control and diagnostic gating bundles.
 * Assumes a 25 MHz core clock; all times below are converted to cycles.
 */
package mpms_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;

    // times as printed, in their own units
    localparam int unsigned RESET_PULSE_NS = 100;
    localparam int unsigned SPI_READY_US = 200;
    localparam int unsigned SETTLE_MS = 5;
    localparam int unsigned RELAY_US = 100;
    localparam int unsigned TICK_MIN = 2;

    // cycle counts; a least time rounds up
    localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * 25 + 999) / 1000;
    localparam int unsigned SPI_READY_CYC = SPI_READY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1_000);
    localparam int unsigned RELAY_CYC = RELAY_US * (CLK_HZ / 1_000_000);
    localparam longint unsigned TICK_CYC = 64'(TICK_MIN) * 64'd60 * 64'(CLK_HZ);

    localparam int unsigned PDT_W = 8;
    localparam logic [PDT_W-1:0] PDT_RESET = 8'h00;
    localparam logic [PDT_W-1:0] PDT_OFF = 8'h00;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned PRE_W = 32;
    localparam int unsigned HARDWARE_POWERDOWN_SELECT_BIT = 2;
    localparam int unsigned CH_N = 8;

    typedef enum logic [2:0] {
        MPMS_OFF     = 3'b000,
        MPMS_WAKING  = 3'b001,
        MPMS_ACTIVE  = 3'b010,
        MPMS_PARTIAL = 3'b011
    } mpms_state_t;

    // software control bundle
    typedef struct packed {
        logic [7:0] ctrl1;          // bit HARDWARE_POWERDOWN_SELECT_BIT selects hardware power-down
        logic       balance_driver_power;
        logic       partial_req;
        logic       soft_reset;
        logic       pdt_write;
        logic [7:0] pdt_data;
    } mpms_ctrl_t;

    // diagnostic gating bundle
    typedef struct packed {
        logic [CH_N-1:0] balance_bits;
        logic [CH_N-1:0] open_sense_control_reg;
        logic [3:0]      open_sense_aux_control_reg;
        logic            conversion_delay_select;
        logic            conversion_order_select;
        logic [1:0]      input_sense_select;
        logic [1:0]      output_gate_enable;   // [0] balance, [1] open sense
    } mpms_diag_t;

endpackage : mpms_pkg

//--- core/mpms_sync.sv
/*
 * Two-flop synchroniser for one level arriving from a pin.
 * Assumes the first flop is read only by the second.
 */
`timescale 1ns/1ns
module mpms_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : mpms_sync

//--- core/mpms_delay.sv
/*
 * Restartable one-shot delay: done rises COUNT cycles after start and holds
 * until clear. Assumes start and clear are synchronous to clk.
 */
`timescale 1ns/1ns
module mpms_delay #(
    parameter int unsigned COUNT = 4,
    parameter int unsigned W     = 24
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic start,
    input  wire logic clear,
    output logic      done
);
    logic [W-1:0] cnt_q;
    logic         run_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done  <= 1'b0;
        end else if (clear) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done  <= 1'b0;
        end else if (start) begin
            cnt_q <= '0;
            run_q <= 1'b1;
            done  <= 1'b0;
        end else if (run_q) begin
            if (cnt_q == W'(COUNT - 1)) begin
                run_q <= 1'b0;
                done  <= 1'b1;
            end
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule : mpms_delay

//--- verif/mpms_host_model.sv
/*
 * Host and lower chain neighbour: drives the supply, reset and wake pins.
 * Assumes the bench gives level requests on the sequencer clock.
 */
`timescale 1ns/1ns
module mpms_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // bench requests
    input  wire logic is_master,
    input  wire logic supply_req,
    input  wire logic reset_req,
    input  wire logic chain_req,
    input  wire logic core_regulator_output,
    // pins
    output logic      interface_supply_sense,
    output logic      reset_pin,
    output logic      chain_wake_in
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interface_supply_sense <= 1'b0;
            reset_pin <= 1'b0;
            chain_wake_in <= 1'b0;
        end else begin
            // a slave's supply pin is tied to its own regulator
            interface_supply_sense <= is_master ? supply_req : core_regulator_output;
            // the reset pin falls with the supply, never driven while it is low; chain wake is not gated
            reset_pin <= reset_req & supply_req;
            // direct chain here; an isolated chain needs dummy writes instead
            chain_wake_in <= chain_req;
        end
    end
endmodule : mpms_host_model

//--- verif/mpms_sequencer_checker.sv
/*
 * Assertions on the sequencer's ports, bound to every instance.
 * Assumes one clock domain and the package's cycle constants.
 */
`timescale 1ns/1ns
module mpms_sequencer_checker
    import mpms_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = 200
) (
    // clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // inputs
    input wire logic                         is_master,
    input wire logic                         interface_supply_sense,
    input wire logic                         watchdog_timeout,
    input mpms_pkg::mpms_ctrl_t              ctrl,
    input mpms_pkg::mpms_diag_t              diag,
    // outputs
    input mpms_pkg::mpms_state_t             state,
    input wire logic                         spi_ready,
    input wire logic                         conv_ready,
    input wire logic                         chain_wake_out,
    input wire logic [mpms_pkg::PDT_W-1:0]   powerdown_time_setting,
    input wire logic [mpms_pkg::PDT_W-1:0]   pd_count,
    input wire logic [4:0]                   dev_addr,
    input wire logic [mpms_pkg::CH_N-1:0]    balance_out,
    input wire logic [mpms_pkg::CH_N-1:0]    open_sense_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    int unsigned awake_cnt;

    // latencies are judged from the state leaving off
    always_ff @(posedge clk or posedge rst) begin
        if (rst || state == MPMS_OFF) begin
            awake_cnt <= 0;
        end else begin
            awake_cnt <= awake_cnt + 1;
        end
    end

    property p_wake;
        is_master && $rose(interface_supply_sense) && state == MPMS_OFF && !watchdog_timeout |-> ##[2:8] state == MPMS_WAKING;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake after supply rise");
    property p_spi;
        $rose(spi_ready) |-> awake_cnt >= SPI_READY_CYC - 8 && awake_cnt <= SPI_READY_CYC + 8;
    endproperty
    a_spi: assert property (p_spi) else $error("serial ready at wrong time");
    property p_conv;
        $rose(conv_ready) |-> awake_cnt >= SETTLE_CYCLES - 8 && awake_cnt <= SETTLE_CYCLES + 8;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion ready at wrong time");
    property p_relay;
        $rose(chain_wake_out) |-> awake_cnt >= RELAY_CYC - 8 && awake_cnt <= RELAY_CYC + 8;
    endproperty
    a_relay: assert property (p_relay) else $error("chain wake at wrong time");
    property p_soft;
        ctrl.soft_reset |=> $stable(dev_addr) [*3];
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset changed address");
    property p_restart;
        ctrl.pdt_write |-> ##[1:3] pd_count == 8'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("count not restarted");
    property p_supply_low;
        is_master && $fell(interface_supply_sense) && powerdown_time_setting == 8'h00 && state != MPMS_OFF
            |-> ##[1:8] state == MPMS_OFF;
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("no power-down on supply low");
    property p_hardware_powerdown_select;
        is_master && state != MPMS_OFF && ctrl.ctrl1[HARDWARE_POWERDOWN_SELECT_BIT] && interface_supply_sense
            && $past(interface_supply_sense, 4) && !watchdog_timeout |=> state != MPMS_OFF;
    endproperty
    a_hardware_powerdown_select: assert property (p_hardware_powerdown_select) else $error("master off with supply high");
    property p_gate;
        !diag.conversion_delay_select && diag.output_gate_enable == 2'b00 && $stable(diag)
            |-> balance_out == '0 && open_sense_out == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("gated outputs active");
    property p_watchdog;
        watchdog_timeout && state != MPMS_OFF |-> ##[1:8] state == MPMS_OFF;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("no power-down on timeout");
endmodule : mpms_sequencer_checker

bind mpms_sequencer mpms_sequencer_checker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_checker (
    .clk, .rst, .is_master, .interface_supply_sense, .watchdog_timeout, .ctrl, .diag, .state,
    .spi_ready, .conv_ready, .chain_wake_out, .powerdown_time_setting, .pd_count, .dev_addr,
    .balance_out, .open_sense_out
);

//--- verif/tb_mpms_sequencer.sv
/*
 * Self-checking bench for the power-mode sequencer; supply, reset and chain wake pins come from the host model.
 * Assumes short tick and settle counts so the run stays brief.
 */
`timescale 1ns/1ns
module tb_mpms_sequencer;
    import mpms_pkg::*;
    localparam int TK = 4;
    localparam int ST = 200;
    localparam int LIMIT = 20000;

    logic                  clk, rst, is_master, supply_req, reset_req, chain_req;
    logic                  watchdog_timeout, dev_addr_load, awake, off;
    logic                  interface_supply_sense, reset_pin, chain_wake_in, spi_ready, conv_ready;
    logic                  chain_wake_out, core_regulator_output, pd_timer_running, regs_default;
    logic [4:0]            dev_addr_in, dev_addr;
    logic [PDT_W-1:0]      powerdown_time_setting, pd_count;
    logic [CH_N-1:0]       balance_out, open_sense_out;
    mpms_ctrl_t            ctrl;
    mpms_diag_t            diag;
    mpms_state_t           state;
    int                    cycles = 0;
    int                    t0 = 0;
    int                    fail_count = 0;
    int                    total_checks = 0;

    mpms_host_model host (
        .clk, .rst, .is_master, .supply_req, .reset_req, .chain_req, .core_regulator_output,
        .interface_supply_sense, .reset_pin, .chain_wake_in
    );
    mpms_sequencer #(
        .TICK_CYCLES(TK),
        .SETTLE_CYCLES(ST)
    ) dut (
        .clk, .rst, .is_master, .interface_supply_sense, .reset_pin, .chain_wake_in, .watchdog_timeout,
        .ctrl, .diag, .dev_addr_in, .dev_addr_load, .state, .spi_ready, .conv_ready, .chain_wake_out,
        .core_regulator_output, .powerdown_time_setting, .pd_count, .pd_timer_running, .dev_addr,
        .regs_default, .balance_out, .open_sense_out
    );

    always_comb awake = (state != MPMS_OFF);
    always_comb off = (state == MPMS_OFF);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // cycles are counted from t0
    task automatic wait_hi(ref logic s, input int lo, input int hi, input string nm);
        while (s !== 1'b1 && cycles - t0 <= hi) @(posedge clk);
        chk(nm, 8'h01, 8'(cycles - t0 >= lo && cycles - t0 <= hi));
    endtask : wait_hi

    task automatic wr_pdt(input logic [7:0] v);
        ctrl.pdt_data <= v;
        ctrl.pdt_write <= 1'b1;
        cyc(1);
        ctrl.pdt_write <= 1'b0;
    endtask : wr_pdt

    initial begin
        rst = 1'b1;
        {is_master, supply_req, reset_req, chain_req, watchdog_timeout, dev_addr_load} = 6'h20;
        dev_addr_in = 5'h00;
        ctrl = '0;
        diag = '0;
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        chk("setting", 8'h00, powerdown_time_setting);
        t0 = cycles;
        supply_req <= 1'b1;
        wait_hi(awake, 2, 8, "wake");
        wait_hi(conv_ready, ST, ST + 12, "conv_ready");
        wait_hi(chain_wake_out, RELAY_CYC, RELAY_CYC + 12, "relay");
        wait_hi(spi_ready, SPI_READY_CYC, SPI_READY_CYC + 12, "spi_ready");
        dev_addr_in <= 5'h0b;
        dev_addr_load <= 1'b1;
        cyc(1);
        dev_addr_load <= 1'b0;
        wr_pdt(8'h05);
        cyc(2);
        chk("setting", 8'h05, powerdown_time_setting);
        ctrl.soft_reset <= 1'b1;
        cyc(1);
        ctrl.soft_reset <= 1'b0;
        cyc(1);
        chk("regs_default", 8'h01, 8'(regs_default));
        cyc(2);
        chk("dev_addr", 8'h0b, 8'(dev_addr));
        chk("setting", 8'h00, powerdown_time_setting);
        diag.open_sense_control_reg <= 8'h3c;
        diag.balance_bits <= 8'ha5;
        diag.output_gate_enable <= 2'b01;
        ctrl.balance_driver_power <= 1'b1;
        ctrl.partial_req <= 1'b1;
        cyc(6);
        chk("state", 8'(MPMS_PARTIAL), 8'(state));
        chk("regulator", 8'h01, 8'(core_regulator_output));
        chk("balance", 8'ha5, balance_out);
        chk("open_sense", 8'h00, open_sense_out);
        diag.output_gate_enable <= 2'b10;
        cyc(4);
        chk("balance", 8'h00, balance_out);
        chk("open_sense", 8'h3c, open_sense_out);
        diag.output_gate_enable <= 2'b00;
        cyc(4);
        chk("balance", 8'h00, balance_out);
        chk("open_sense", 8'h00, open_sense_out);
        diag.conversion_delay_select <= 1'b1;
        cyc(4);
        chk("balance", 8'ha5, balance_out);
        chk("open_sense", 8'h3c, open_sense_out);
        ctrl.partial_req <= 1'b0;
        diag <= '0;
        cyc(4);
        t0 = cycles;
        supply_req <= 1'b0;
        wait_hi(off, 2, 10, "pd_now");
        chk("regulator", 8'h00, 8'(core_regulator_output));
        supply_req <= 1'b1;
        cyc(20);
        wr_pdt(8'h06);
        ctrl.ctrl1[HARDWARE_POWERDOWN_SELECT_BIT] <= 1'b1;
        for (int i = 0; i < 4 * TK && pd_count !== 8'h01; i++) cyc(1);
        cyc(TK);
        chk("pd_count", 8'h02, pd_count);
        chk("running", 8'h01, 8'(pd_timer_running));
        chk("awake", 8'h01, 8'(awake));
        wr_pdt(8'h06);
        cyc(2);
        chk("pd_count", 8'h00, pd_count);
        t0 = cycles;
        supply_req <= 1'b0;
        cyc(8);
        chk("awake", 8'h01, 8'(awake));
        wait_hi(off, 6 * TK - 4, 6 * TK + 12, "pd_timer");
        ctrl.ctrl1 <= 8'h00;
        supply_req <= 1'b1;
        cyc(20);
        watchdog_timeout <= 1'b1;
        cyc(2);
        watchdog_timeout <= 1'b0;
        cyc(10);
        chk("awake", 8'h00, 8'(awake));
        reset_req <= 1'b1;
        cyc(2);
        reset_req <= 1'b0;
        cyc(10);
        chk("awake", 8'h00, 8'(awake));
        t0 = cycles;
        reset_req <= 1'b1;
        cyc(4);
        reset_req <= 1'b0;
        wait_hi(awake, 4, 20, "reset_wake");
        chk("dev_addr", 8'h00, 8'(dev_addr));
        rst <= 1'b1;
        is_master <= 1'b0;
        supply_req <= 1'b0;
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        t0 = cycles;
        chain_req <= 1'b1;
        wait_hi(conv_ready, ST, ST + 12, "slave_conv");
        wait_hi(chain_wake_out, RELAY_CYC, RELAY_CYC + 12, "slave_relay");
        chain_req <= 1'b0;
        wr_pdt(8'h02);
        t0 = cycles;
        ctrl.ctrl1[HARDWARE_POWERDOWN_SELECT_BIT] <= 1'b1;
        wait_hi(off, 2 * TK, 2 * TK + 12, "slave_pd");
        summarize();
    end
endmodule : tb_mpms_sequencer
